// ==== src/rtc_alarm_pkg.sv ====
package rtc_alarm_pkg;

    localparam int REG_ADDR_W = 8;
    localparam int MAX_ALARMS = 2;

    // register offsets
    localparam logic [7:0] OFS_RW = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ALM_TIME [MAX_ALARMS] = '{8'h08, 8'h10};
    localparam logic [7:0] OFS_ALM_DATE [MAX_ALARMS] = '{8'h0c, 8'h14};
    localparam logic [7:0] OFS_INTR = 8'h18;
    localparam logic [7:0] OFS_INTR_MASK = 8'h1c;
    localparam logic [7:0] OFS_INTR_MASKED = 8'h20;
    localparam logic [7:0] OFS_DEEP_OFF = 8'h24;

    // read/write control, status busy and hibernate gate fields
    localparam int RW_READ_BIT = 0;
    localparam int RW_WRITE_BIT = 1;
    localparam int RW_HR12_BIT = 2;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int HIB_GATE_BIT = 0;

    // alarm time word fields
    localparam int SEC_LSB = 0;
    localparam int SEC_EN_BIT = 7;
    localparam int MIN_LSB = 8;
    localparam int MIN_EN_BIT = 15;
    localparam int HOUR_LSB = 16;
    localparam int HOUR_EN_BIT = 23;
    localparam int DAY_LSB = 24;
    localparam int DAY_EN_BIT = 31;
    // alarm date word fields
    localparam int DATE_LSB = 0;
    localparam int DATE_EN_BIT = 7;
    localparam int MON_LSB = 8;
    localparam int MON_EN_BIT = 15;
    localparam int MASTER_BIT = 31;

    // interrupt source bits
    localparam int IRQ_CENTURY_BIT = 2;
    localparam int IRQ_W = 3;

    // reset values and century rollover years
    localparam logic [IRQ_W-1:0] INTR_RST = 3'h0;
    localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
    localparam logic [7:0] YEAR_RST = 8'h00;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [7:0] YEAR_FIRST = 8'h00;

    typedef struct packed {
        logic [3:0] mon;
        logic [5:0] date;
        logic [2:0] day;
        logic [5:0] hour;
        logic [6:0] min;
        logic [6:0] sec;
    } cal_s;

    typedef struct packed {
        logic [7:0] year;
        cal_s cal;
    } rtc_now_s;

    typedef struct packed {
        logic master;
        logic mon_en;
        logic date_en;
        logic day_en;
        logic hour_en;
        logic min_en;
        logic sec_en;
        cal_s val;
    } alarm_s;

    localparam alarm_s ALARM_RST = '0;

endpackage

// ==== src/rtc_alarm_match.sv ====
// Summary of operation
// (RULE1) alarms compare month, date, weekday, hour, minute, second
// (RULE2) each field has own enable bit
// (RULE3) seconds value is 7-bit BCD
// (RULE4) minutes value is 7-bit BCD
// (RULE5) hours value is 6-bit BCD, AM/PM
// (RULE6) weekday value is 3-bit BCD 1-7
// (RULE7) day-of-month value is 6-bit BCD
// (RULE8) month value is 4-bit BCD
// (RULE9) master enable low blocks alarm
// (RULE10) no fields enabled: interrupt every second
// (RULE11) two independent alarms with own settings
// (RULE12) alarm registers use freeze and commit handshake
// (RULE13) mask bits gate each interrupt source
// (RULE14) century interrupt on year 99 to 00
// (RULE15) alarm interrupt wakes sleep states
// (RULE16) hibernate wake only while gate bit set
// (RULE17) read request freezes copy, refused when busy
// (RULE18) writes need write request; commit on one edge
// (RULE19) twelve hour select picks hour format
// (RULE20) flag set once when enabled fields match
`timescale 1ns/10ps
`default_nettype none

module rtc_alarm_match
    import rtc_alarm_pkg::*;
#(
    parameter int ALARM_COUNT = 2
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [REG_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic low_freq_crystal_clock,
    input wire logic sec_update,
    input wire rtc_now_s rtc_now,
    output logic twelve_hour_select,
    output logic irq,
    output logic wake_sleep,
    output logic wake_hibernate
);

    if (ALARM_COUNT < 1 || ALARM_COUNT > MAX_ALARMS) begin : g_bad_count
        $error("ALARM_COUNT must be 1 or 2");
    end

    if (IRQ_CENTURY_BIT != MAX_ALARMS || IRQ_W != MAX_ALARMS + 1) begin : g_bad_irq
        $error("interrupt bits must be the alarms, then century");
    end

    function automatic logic alarm_hit(input alarm_s a, input cal_s now);
        logic hit;
        hit = a.master; // RULE9
        if (a.sec_en && a.val.sec != now.sec) hit = 1'b0; // RULE2
        if (a.min_en && a.val.min != now.min) hit = 1'b0;
        if (a.hour_en && a.val.hour != now.hour) hit = 1'b0;
        if (a.day_en && a.val.day != now.day) hit = 1'b0;
        if (a.date_en && a.val.date != now.date) hit = 1'b0;
        if (a.mon_en && a.val.mon != now.mon) hit = 1'b0;
        return hit; // RULE10
    endfunction

    function automatic logic [31:0] pack_time(input alarm_s a);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SEC_LSB +: 7] = a.val.sec;
        w[SEC_EN_BIT] = a.sec_en;
        w[MIN_LSB +: 7] = a.val.min;
        w[MIN_EN_BIT] = a.min_en;
        w[HOUR_LSB +: 6] = a.val.hour;
        w[HOUR_EN_BIT] = a.hour_en;
        w[DAY_LSB +: 3] = a.val.day;
        w[DAY_EN_BIT] = a.day_en;
        return w;
    endfunction

    function automatic logic [31:0] pack_date(input alarm_s a);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[DATE_LSB +: 6] = a.val.date;
        w[DATE_EN_BIT] = a.date_en;
        w[MON_LSB +: 4] = a.val.mon;
        w[MON_EN_BIT] = a.mon_en;
        w[MASTER_BIT] = a.master;
        return w;
    endfunction

    function automatic alarm_s load_time(input alarm_s a, input logic [31:0] w);
        alarm_s r;
        r = a;
        r.val.sec = w[SEC_LSB +: 7]; // RULE3
        r.sec_en = w[SEC_EN_BIT];
        r.val.min = w[MIN_LSB +: 7]; // RULE4
        r.min_en = w[MIN_EN_BIT];
        r.val.hour = w[HOUR_LSB +: 6]; // RULE5
        r.hour_en = w[HOUR_EN_BIT];
        r.val.day = w[DAY_LSB +: 3]; // RULE6
        r.day_en = w[DAY_EN_BIT];
        return r;
    endfunction

    function automatic alarm_s load_date(input alarm_s a, input logic [31:0] w);
        alarm_s r;
        r = a;
        r.val.date = w[DATE_LSB +: 6]; // RULE7
        r.date_en = w[DATE_EN_BIT];
        r.val.mon = w[MON_LSB +: 4]; // RULE8
        r.mon_en = w[MON_EN_BIT];
        r.master = w[MASTER_BIT];
        return r;
    endfunction

    // one select bit per alarm time word
    function automatic logic [MAX_ALARMS-1:0] time_sel(input logic [REG_ADDR_W-1:0] a);
        logic [MAX_ALARMS-1:0] s;
        s = '0;
        for (int i = 0; i < ALARM_COUNT; i++) begin
            s[i] = (a == OFS_ALM_TIME[i]);
        end
        return s;
    endfunction

    // one select bit per alarm date word
    function automatic logic [MAX_ALARMS-1:0] date_sel(input logic [REG_ADDR_W-1:0] a);
        logic [MAX_ALARMS-1:0] s;
        s = '0;
        for (int i = 0; i < ALARM_COUNT; i++) begin
            s[i] = (a == OFS_ALM_DATE[i]);
        end
        return s;
    endfunction

    logic read_req;
    logic write_req;
    logic commit_pend;
    logic hr12;
    logic hib_gate;
    logic [IRQ_W-1:0] intr;
    logic [IRQ_W-1:0] mask;
    logic [7:0] prev_year;
    alarm_s user_alm [ALARM_COUNT];
    alarm_s live_alm [ALARM_COUNT];

    logic next_read_req;
    logic next_write_req;
    logic next_commit_pend;
    logic next_hr12;
    logic next_hib_gate;
    logic [IRQ_W-1:0] next_intr;
    logic [IRQ_W-1:0] next_mask;
    logic [7:0] next_prev_year;
    logic [31:0] next_rdata;
    alarm_s next_user_alm [ALARM_COUNT];
    alarm_s next_live_alm [ALARM_COUNT];

    logic [IRQ_W-1:0] intr_set;
    logic [IRQ_W-1:0] intr_masked;
    logic [MAX_ALARMS-1:0] alarm_match;
    logic [MAX_ALARMS-1:0] time_hit;
    logic [MAX_ALARMS-1:0] date_hit;

    assign time_hit = time_sel(addr);
    assign date_hit = date_sel(addr);

    // one comparator per alarm; slots beyond the count never fire
    for (genvar g = 0; g < MAX_ALARMS; g++) begin : g_alarm
        if (g < ALARM_COUNT) begin : g_used
            assign alarm_match[g] = alarm_hit(live_alm[g], rtc_now.cal); // RULE1 RULE11
        end else begin : g_unused
            assign alarm_match[g] = 1'b0;
        end
    end

    always_comb begin
        intr_set = '0;
        if (sec_update) begin
            intr_set[MAX_ALARMS-1:0] = alarm_match; // RULE20
        end
        if (prev_year == YEAR_LAST && rtc_now.year == YEAR_FIRST) begin
            intr_set[IRQ_CENTURY_BIT] = 1'b1; // RULE14
        end
    end

    assign intr_masked = intr & mask; // RULE13

    always_comb begin
        next_read_req = read_req;
        next_write_req = write_req;
        next_commit_pend = commit_pend;
        next_hr12 = hr12;
        next_hib_gate = hib_gate;
        next_intr = intr;
        next_mask = mask;
        next_prev_year = rtc_now.year;
        next_rdata = 32'h0000_0000;
        next_user_alm = user_alm;
        next_live_alm = live_alm;

        // new values reach the live alarms on the first core clock edge with the crystal clock high
        if (commit_pend && low_freq_crystal_clock) begin
            next_live_alm = user_alm; // RULE18
            next_commit_pend = 1'b0;
        end

        if (wr) begin
            if (addr == OFS_RW) begin
                next_hr12 = wdata[RW_HR12_BIT]; // RULE19
                if (!wdata[RW_READ_BIT]) begin
                    next_read_req = 1'b0;
                end else if (!read_req && !commit_pend && !write_req) begin
                    next_read_req = 1'b1; // RULE17
                    next_user_alm = live_alm; // RULE12
                end
                if (!wdata[RW_WRITE_BIT]) begin
                    if (write_req) begin
                        next_write_req = 1'b0;
                        next_commit_pend = 1'b1; // RULE18
                    end
                end else if (!write_req && !commit_pend && !read_req
                             && !next_read_req) begin
                    next_write_req = 1'b1;
                end
            end else if (addr == OFS_INTR) begin
                next_intr = intr & ~wdata[IRQ_W-1:0];
            end else if (addr == OFS_INTR_MASK) begin
                next_mask = wdata[IRQ_W-1:0];
            end else if (addr == OFS_DEEP_OFF) begin
                next_hib_gate = wdata[HIB_GATE_BIT];
            end else if (write_req) begin
                for (int i = 0; i < ALARM_COUNT; i++) begin
                    if (time_hit[i]) begin
                        next_user_alm[i] = load_time(user_alm[i], wdata); // RULE12
                    end else if (date_hit[i]) begin
                        next_user_alm[i] = load_date(user_alm[i], wdata);
                    end
                end
            end
        end

        // a new event beats a clear in the same cycle
        next_intr = next_intr | intr_set;

        if (rd) begin
            if (addr == OFS_RW) begin
                next_rdata[RW_READ_BIT] = read_req;
                next_rdata[RW_WRITE_BIT] = write_req;
                next_rdata[RW_HR12_BIT] = hr12;
            end else if (addr == OFS_STATUS) begin
                next_rdata[STATUS_BUSY_BIT] = commit_pend;
            end else if (addr == OFS_INTR) begin
                next_rdata[IRQ_W-1:0] = intr;
            end else if (addr == OFS_INTR_MASK) begin
                next_rdata[IRQ_W-1:0] = mask;
            end else if (addr == OFS_INTR_MASKED) begin
                next_rdata[IRQ_W-1:0] = intr_masked;
            end else if (addr == OFS_DEEP_OFF) begin
                next_rdata[HIB_GATE_BIT] = hib_gate;
            end else begin
                for (int i = 0; i < ALARM_COUNT; i++) begin
                    if (time_hit[i]) begin
                        next_rdata = pack_time(user_alm[i]);
                    end else if (date_hit[i]) begin
                        next_rdata = pack_date(user_alm[i]);
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            read_req <= 1'b0;
            write_req <= 1'b0;
            commit_pend <= 1'b0;
            hr12 <= 1'b0;
            hib_gate <= 1'b0;
            intr <= INTR_RST;
            mask <= MASK_RST;
            prev_year <= YEAR_RST;
            rdata <= 32'h0000_0000;
            for (int i = 0; i < ALARM_COUNT; i++) begin
                user_alm[i] <= ALARM_RST;
                live_alm[i] <= ALARM_RST;
            end
        end else begin
            read_req <= next_read_req;
            write_req <= next_write_req;
            commit_pend <= next_commit_pend;
            hr12 <= next_hr12;
            hib_gate <= next_hib_gate;
            intr <= next_intr;
            mask <= next_mask;
            prev_year <= next_prev_year;
            rdata <= next_rdata;
            user_alm <= next_user_alm;
            live_alm <= next_live_alm;
        end
    end

    assign twelve_hour_select = hr12; // RULE19
    assign irq = |intr_masked;
    assign wake_sleep = irq; // RULE15
    assign wake_hibernate = irq & hib_gate; // RULE16

endmodule

`default_nettype wire

// ==== bench/rtc_alarm_match_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module rtc_alarm_match_asserts
    import rtc_alarm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [REG_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic low_freq_crystal_clock,
    input wire logic sec_update,
    input wire rtc_now_s rtc_now,
    input wire logic twelve_hour_select,
    input wire logic irq,
    input wire logic wake_sleep,
    input wire logic wake_hibernate
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_mwr;
        wr && addr == OFS_INTR_MASK;
    endsequence
    sequence s_mrd;
        rd && addr == OFS_INTR_MASK;
    endsequence
    property p_wake;
        wake_sleep == irq;
    endproperty
    a_wake: assert property (p_wake) else $error("sleep wake differs from irq");
    property p_hib;
        wake_hibernate |-> irq;
    endproperty
    a_hib: assert property (p_hib) else $error("hibernate wake without irq");
    property p_irq_cause;
        $rose(irq) |-> $past(sec_update) || $past(wr)
            || ($past(rtc_now.year, 2) == YEAR_LAST && $past(rtc_now.year) == YEAR_FIRST);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
    property p_irq_fall;
        $fell(irq) |-> $past(wr);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    property p_hr12_chg;
        $changed(twelve_hour_select) |-> $past(wr && addr == OFS_RW);
    endproperty
    a_hr12_chg: assert property (p_hr12_chg) else $error("hour format moved alone");
    property p_hr12_val;
        wr && addr == OFS_RW |=> twelve_hour_select == $past(wdata[RW_HR12_BIT]);
    endproperty
    a_hr12_val: assert property (p_hr12_val) else $error("hour format not taken");
    property p_mask_rb;
        s_mwr ##1 !wr ##1 s_mrd |=> rdata == {29'h0, $past(wdata[IRQ_W-1:0], 3)};
    endproperty
    a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
    property p_rd_idle;
        !rd |=> rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
    property p_unmapped;
        rd && addr == 8'h40 |=> rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind rtc_alarm_match rtc_alarm_match_asserts u_chk (.*);
`default_nettype wire

// ==== bench/rtc_alarm_match_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module rtc_alarm_match_tb
    import rtc_alarm_pkg::*;
;
    logic core_clk = 0, rstn = 0, wr = 0, rd = 0, lf = 0, su = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    rtc_now_s now = '0;
    logic hr12, irq, wk_s, wk_h;
    int miscompares = 0, cmp_count = 0, seed = 32'h1248;
    int tw[2], dw[2];
    logic [1:0] h;
    rtc_alarm_match u_dut (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .low_freq_crystal_clock(lf), .sec_update(su),
        .rtc_now(now), .twelve_hour_select(hr12), .irq(irq), .wake_sleep(wk_s),
        .wake_hibernate(wk_h));
    always #25 core_clk = ~core_clk;
    task results;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task wrr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task rdr(logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // writes behind the write request, one crystal edge commits
    task setal(int i, int t, int d);
        wrr(OFS_RW, 32'h2);
        wrr(OFS_ALM_TIME[i], t);
        wrr(OFS_ALM_DATE[i], d);
    endtask
    task commit;
        wrr(OFS_RW, 32'h0);
        rdr(OFS_STATUS, v);
        chk("busy_set", 32'h1, v);
        @(posedge core_clk);
        lf <= 1'b1;
        @(posedge core_clk);
        lf <= 1'b0;
        repeat (2) @(posedge core_clk);
        rdr(OFS_STATUS, v);
        chk("busy_clr", 32'h0, v);
    endtask
    function bit hit(int t, int d, rtc_now_s n);
        hit = d[31];
        if (t[7] && t[6:0] != n.cal.sec) hit = 0;
        if (t[15] && t[14:8] != n.cal.min) hit = 0;
        if (t[23] && t[21:16] != n.cal.hour) hit = 0;
        if (t[31] && t[26:24] != n.cal.day) hit = 0;
        if (d[7] && d[5:0] != n.cal.date) hit = 0;
        if (d[15] && d[11:8] != n.cal.mon) hit = 0;
    endfunction
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        results();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        now.year <= 8'h10;
        rdr(OFS_INTR_MASK, v);
        chk("mask_rst", 32'h0, v);
        wrr(OFS_INTR_MASK, 32'h7);
        rdr(OFS_INTR_MASK, v);
        chk("mask", 32'h7, v);
        $display("test reset done");
        for (int k = 0; k < 24; k++) begin
            for (int i = 0; i < 2; i++) begin
                tw[i] = $random(seed) & 32'h87bfffff;
                dw[i] = $random(seed) & 32'h80008fbf;
                if (k < 2) dw[i] = dw[i] | 32'h80000000;
                setal(i, tw[i], dw[i]);
            end
            if (k == 0) tw[0] = 0;
            if (k == 0) dw[0] = 32'h80000000;
            if (k == 1) dw[0] = 32'h8080;
            setal(0, tw[0], dw[0]);
            commit();
            rdr(OFS_ALM_TIME[0], v);
            chk("time_rb", tw[0], v);
            rdr(OFS_ALM_DATE[1], v);
            chk("date_rb", dw[1], v);
            @(posedge core_clk);
            now.cal <= {dw[0][11:8], dw[0][5:0], tw[0][26:24], tw[0][21:16],
                tw[0][14:8], tw[0][6:0]} ^ ((k % 3 == 2) ? 33'h1 << (k % 33) : 33'h0);
            su <= 1'b1;
            @(posedge core_clk);
            su <= 1'b0;
            #1;
            h = {hit(tw[1], dw[1], now), hit(tw[0], dw[0], now)};
            rdr(OFS_INTR, v);
            chk("intr", {30'h0, h}, v);
            chk("irq", {31'h0, |h}, {31'h0, irq});
            wrr(OFS_INTR, 32'h7);
        end
        wrr(OFS_ALM_TIME[0], ~tw[0]);
        rdr(OFS_ALM_TIME[0], v);
        chk("ignored", tw[0], v);
        wrr(OFS_RW, 32'h2);
        wrr(OFS_RW, 32'h3);
        rdr(OFS_RW, v);
        chk("rd_refused", 32'h2, v);
        wrr(OFS_RW, 32'h0);
        wrr(OFS_RW, 32'h1);
        rdr(OFS_RW, v);
        chk("rd_busy", 32'h0, v);
        commit();
        wrr(OFS_RW, 32'h1);
        wrr(OFS_RW, 32'h3);
        rdr(OFS_RW, v);
        chk("rd_set", 32'h1, v);
        rdr(OFS_ALM_DATE[0], v);
        chk("frozen", dw[0], v);
        wrr(OFS_RW, 32'h0);
        $display("test match done");
        wrr(OFS_INTR_MASK, 32'h3);
        @(posedge core_clk);
        now.year <= 8'h99;
        @(posedge core_clk);
        now.year <= 8'h00;
        repeat (2) @(posedge core_clk);
        #1 chk("irq_masked", 32'h0, {31'h0, irq});
        rdr(OFS_INTR, v);
        chk("century", 32'h4, v);
        wrr(OFS_INTR_MASK, 32'h7);
        #1 chk("hib_gated", 32'h0, {31'h0, wk_h});
        rdr(OFS_INTR_MASKED, v);
        chk("masked", 32'h4, v);
        wrr(OFS_DEEP_OFF, 32'h1);
        #1 chk("hib_wake", 32'h1, {31'h0, wk_h});
        chk("sleep_wake", 32'h1, {31'h0, wk_s});
        wrr(OFS_RW, 32'h4);
        #1 chk("hr12", 32'h1, {31'h0, hr12});
        rdr(8'h40, v);
        chk("unmapped", 32'h0, v);
        $display("test irq done");
        results();
    end
endmodule
`default_nettype wire
